// *** hw/cpu_exception_dispatch.v ***
// Exception and interrupt dispatch: frame push, vector fetch, restart
// Summary of operation
// [RULE1] Emulation frame: opcode, opcode PC, eight specifiers, next PC, status.
// [RULE2] Specifier words hold address for write/address, value for read operands.
// [RULE3] Unused specifier words of the emulation frame carry any value.
// [RULE4] Emulation trap frame PC is the address of the following instruction.
// [RULE5] First-part-done set: emulation faults via CC, saved PC is opcode address.
// [RULE6] Vector instructions fault via 68, pushing only PC and status.
// [RULE7] Internal error takes machine check via 04 with identifying frame.
// [RULE8] Machine check frame carries six parameters beyond PC and status.
// [RULE9] Inconsistency, kernel halt or reset: save state, jump to E0040000.
// [RULE10] Restart saves SP to mode IPR, PC to IPR 42, status to 43.
// [RULE11] Fault while pushing kernel stack gives kernel-stack-invalid abort via 08.
// [RULE12] Kernel-stack-invalid abort runs on interrupt stack with no parameters.
// [RULE13] Fault while pushing interrupt stack starts restart with stack error code.
// [RULE14] Vectors come from a two-page table at the table base register.
// [RULE15] Passive release dispatches via 00, level raised to request level.
// [RULE16] Power fail dispatches via 0C, level 1E, no parameters.
// [RULE17] Access violation 20 and not-valid 24 push address and status code.
// [RULE18] Arithmetic exceptions via 34, trap or fault, one type code parameter.
// [RULE19] Change-mode traps via 40,44,48,4C push sign-extended operand word.
// [RULE20] Soft error interrupt via 54 at level 1A, no parameters.
// [RULE21] Hard error interrupt via 60 at level 1D, no parameters.
// [RULE22] First-part-done clear: emulation traps via C8.
// [RULE23] Traps save next PC; faults save faulting instruction PC.
// [RULE24] Vector address is table base plus fixed offset.
`timescale 1ns/1ps
`default_nettype none
`include "exc_defines.vh"
module cpu_exception_dispatch (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Request from execution
    input wire req_valid,
    output wire req_ready,
    input wire [3:0] req_kind,
    input wire [31:0] req_pc,
    input wire [31:0] req_next_pc,
    input wire [31:0] req_status,
    input wire [31:0] req_sp,
    input wire [2:0] req_sp_mode,
    input wire req_on_istack,
    input wire [31:0] req_isp,
    input wire [4:0] req_level,
    input wire [7:0] req_opcode,
    input wire [15:0] req_word,
    input wire [5:0] req_halt_code,
    // Parameter source
    output wire [3:0] param_sel,
    input wire [31:0] param_data,
    // Vector table base
    input wire [31:0] vector_table_base,
    // Stack push port
    output reg push_valid_q,
    output reg [31:0] push_addr_q,
    output reg [31:0] push_data_q,
    input wire push_ready,
    input wire push_err,
    // Vector fetch port
    output reg fetch_valid_q,
    output reg [31:0] fetch_addr_q,
    input wire fetch_ready,
    input wire [31:0] fetch_data,
    // Internal register write port
    output reg ipr_wr_valid_q,
    output reg [5:0] ipr_wr_addr_q,
    output reg [31:0] ipr_wr_data_q,
    input wire ipr_wr_ready,
    // Dispatch result
    output reg done_q,
    output reg restarted_q,
    output reg [31:0] new_pc_q,
    output reg [31:0] new_sp_q,
    output reg new_istack_q,
    output reg new_ipl_load_q,
    output reg [4:0] new_ipl_q
);
    // ------
    // States
    // ------
    localparam S_BOOT = 3'd0;
    localparam S_IDLE = 3'd1;
    localparam S_LOAD = 3'd2;
    localparam S_PUSH = 3'd3;
    localparam S_FETCH = 3'd4;
    localparam S_IPR = 3'd5;
    localparam S_DONE = 3'd6;

    // ------
    // Decode functions
    // ------
    function [9:0] vec_off;
        input [3:0] k;
        input first_part_done_flag;
        begin
            case (k)
                `K_PASSIVE: vec_off = `V_PASSIVE; // [RULE15]
                `K_MCHECK: vec_off = `V_MCHECK; // [RULE7]
                `K_KSNV: vec_off = `V_KSNV; // [RULE11]
                `K_PWRFAIL: vec_off = `V_PWRFAIL; // [RULE16]
                `K_ACV: vec_off = `V_ACV; // [RULE17]
                `K_TNV: vec_off = `V_TNV; // [RULE17]
                `K_ARITH: vec_off = `V_ARITH; // [RULE18]
                `K_CHM_KERNEL: vec_off = `V_CHM_KERNEL; // [RULE19]
                `K_CHM_EXEC: vec_off = `V_CHM_EXEC; // [RULE19]
                `K_CHM_SUPER: vec_off = `V_CHM_SUPER; // [RULE19]
                `K_CHM_USER: vec_off = `V_CHM_USER; // [RULE19]
                `K_SOFTERR: vec_off = `V_SOFTERR; // [RULE20]
                `K_HARDERR: vec_off = `V_HARDERR; // [RULE21]
                `K_VECDIS: vec_off = `V_VECDIS; // [RULE6]
                `K_EMUL: vec_off = first_part_done_flag ? `V_EMUL_CONT : `V_EMUL_START; // [RULE5] [RULE22]
                default: vec_off = `V_PASSIVE;
            endcase
        end
    endfunction

    function [3:0] frame_words;
        input [3:0] k;
        input first_part_done_flag;
        begin
            case (k)
                `K_MCHECK: frame_words = `N_MCHECK + 4'h2; // [RULE8]
                `K_ACV, `K_TNV: frame_words = 4'h4; // [RULE17]
                `K_ARITH: frame_words = 4'h3; // [RULE18]
                `K_CHM_KERNEL, `K_CHM_EXEC, `K_CHM_SUPER, `K_CHM_USER: frame_words = 4'h3;
                `K_EMUL: frame_words = first_part_done_flag ? 4'h2 : `FRAME_EMUL; // [RULE1] [RULE5]
                default: frame_words = 4'h2; // [RULE6] [RULE12] [RULE15] [RULE16]
            endcase
        end
    endfunction

    function is_chm;
        input [3:0] k;
        begin
            is_chm = (k == `K_CHM_KERNEL) || (k == `K_CHM_EXEC) ||
                (k == `K_CHM_SUPER) || (k == `K_CHM_USER);
        end
    endfunction

    // ------
    // State registers
    // ------
    reg [2:0] state_q;
    reg [3:0] kind_q;
    reg fpd_q;
    reg [3:0] total_q;
    reg [3:0] cnt_q;
    reg [31:0] sp_q;
    reg [2:0] sp_mode_q;
    reg istack_q;
    reg [31:0] pc_q;
    reg [31:0] opc_pc_q;
    reg [31:0] status_q;
    reg [7:0] opcode_q;
    reg [15:0] word_q;
    reg [4:0] level_q;
    reg [5:0] halt_q;
    reg [1:0] ipr_step_q;
    reg boot_q;

    wire req_fpd;
    wire req_trap;
    wire [3:0] spec_idx;
    reg [31:0] word_d;

    assign req_ready = (state_q == S_IDLE);
    assign req_fpd = req_status[`FPD_BIT];
    // [RULE23]
    assign req_trap = ((req_kind == `K_EMUL) && !req_fpd) || is_chm(req_kind) ||
        ((req_kind == `K_ARITH) && (req_word < `ARITH_FIRST_FAULT));
    assign spec_idx = cnt_q - 4'h2;
    assign param_sel = (kind_q == `K_EMUL) ? spec_idx : cnt_q; // [RULE2] [RULE3]

    // ------
    // Frame word selection
    // ------
    always @* begin
        if (cnt_q == total_q - 4'h1) begin
            word_d = status_q;
        end else if (cnt_q == total_q - 4'h2) begin
            word_d = pc_q; // [RULE4] [RULE23]
        end else if (kind_q == `K_EMUL) begin
            if (cnt_q == 4'h0) begin
                word_d = {24'h000000, opcode_q}; // [RULE1]
            end else if (cnt_q == 4'h1) begin
                word_d = opc_pc_q; // [RULE1]
            end else begin
                word_d = param_data; // [RULE2]
            end
        end else if (is_chm(kind_q)) begin
            word_d = {{16{word_q[15]}}, word_q}; // [RULE19]
        end else if (kind_q == `K_ARITH) begin
            word_d = {16'h0000, word_q}; // [RULE18]
        end else begin
            word_d = param_data; // [RULE8] [RULE17]
        end
    end

    // ------
    // Sequencer
    // ------
    always @(posedge clk_sys) begin
        if (rst) begin
            state_q <= S_BOOT;
            kind_q <= 4'h0;
            fpd_q <= 1'b0;
            total_q <= 4'h0;
            cnt_q <= 4'h0;
            sp_q <= 32'h0;
            sp_mode_q <= 3'h0;
            istack_q <= 1'b0;
            pc_q <= 32'h0;
            opc_pc_q <= 32'h0;
            status_q <= 32'h0;
            opcode_q <= 8'h00;
            word_q <= 16'h0000;
            level_q <= 5'h00;
            halt_q <= 6'h00;
            ipr_step_q <= 2'h0;
            boot_q <= 1'b0;
            push_valid_q <= 1'b0;
            push_addr_q <= 32'h0;
            push_data_q <= 32'h0;
            fetch_valid_q <= 1'b0;
            fetch_addr_q <= 32'h0;
            ipr_wr_valid_q <= 1'b0;
            ipr_wr_addr_q <= 6'h00;
            ipr_wr_data_q <= 32'h0;
            done_q <= 1'b0;
            restarted_q <= 1'b0;
            new_pc_q <= 32'h0;
            new_sp_q <= 32'h0;
            new_istack_q <= 1'b0;
            new_ipl_load_q <= 1'b0;
            new_ipl_q <= 5'h00;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                S_BOOT: begin
                    // Power-up restart
                    pc_q <= req_pc; // [RULE9]
                    status_q <= req_status;
                    sp_q <= req_sp;
                    sp_mode_q <= req_sp_mode;
                    halt_q <= `HALT_POWERUP;
                    boot_q <= 1'b1;
                    ipr_step_q <= 2'h0;
                    state_q <= S_IPR;
                end
                S_IDLE: begin
                    if (req_valid) begin
                        kind_q <= req_kind;
                        fpd_q <= req_fpd;
                        total_q <= frame_words(req_kind, req_fpd);
                        cnt_q <= frame_words(req_kind, req_fpd) - 4'h1;
                        pc_q <= req_trap ? req_next_pc : req_pc; // [RULE23]
                        opc_pc_q <= req_pc;
                        status_q <= req_status;
                        sp_q <= req_sp;
                        sp_mode_q <= req_sp_mode;
                        istack_q <= req_on_istack;
                        opcode_q <= req_opcode;
                        word_q <= req_word;
                        level_q <= req_level;
                        halt_q <= req_halt_code;
                        boot_q <= 1'b0;
                        ipr_step_q <= 2'h0;
                        if (req_kind == `K_RESTART) begin
                            pc_q <= req_pc; // [RULE9]
                            state_q <= S_IPR;
                        end else if (req_kind == `K_KSNV) begin
                            sp_q <= req_isp; // [RULE12]
                            istack_q <= 1'b1;
                            state_q <= S_LOAD;
                        end else begin
                            state_q <= S_LOAD;
                        end
                    end
                end
                S_LOAD: begin
                    push_addr_q <= sp_q - 32'h4;
                    push_data_q <= word_d;
                    push_valid_q <= 1'b1;
                    state_q <= S_PUSH;
                end
                S_PUSH: begin
                    if (push_ready) begin
                        push_valid_q <= 1'b0;
                        if (push_err) begin
                            if (istack_q) begin
                                halt_q <= `HALT_INTSTK_ERR; // [RULE13]
                                pc_q <= opc_pc_q;
                                ipr_step_q <= 2'h0;
                                state_q <= S_IPR;
                            end else begin
                                kind_q <= `K_KSNV; // [RULE11]
                                total_q <= 4'h2;
                                cnt_q <= 4'h1;
                                sp_q <= req_isp; // [RULE12]
                                istack_q <= 1'b1;
                                state_q <= S_LOAD;
                            end
                        end else begin
                            sp_q <= sp_q - 32'h4;
                            if (cnt_q == 4'h0) begin
                                // [RULE14] [RULE24]
                                fetch_addr_q <= {vector_table_base[31:`TABLE_BASE_LSB],
                                    9'h000} + {22'h000000, vec_off(kind_q, fpd_q)};
                                fetch_valid_q <= 1'b1;
                                state_q <= S_FETCH;
                            end else begin
                                cnt_q <= cnt_q - 4'h1;
                                state_q <= S_LOAD;
                            end
                        end
                    end
                end
                S_FETCH: begin
                    if (fetch_ready) begin
                        fetch_valid_q <= 1'b0;
                        new_pc_q <= {fetch_data[31:2], 2'b00};
                        new_sp_q <= sp_q;
                        new_istack_q <= istack_q | fetch_data[0] | (kind_q == `K_KSNV);
                        restarted_q <= 1'b0;
                        new_ipl_load_q <= 1'b1;
                        case (kind_q)
                            `K_PASSIVE: new_ipl_q <= level_q; // [RULE15]
                            `K_PWRFAIL: new_ipl_q <= `IPL_PWRFAIL; // [RULE16]
                            `K_SOFTERR: new_ipl_q <= `IPL_SOFTERR; // [RULE20]
                            `K_HARDERR: new_ipl_q <= `IPL_HARDERR; // [RULE21]
                            default: new_ipl_load_q <= 1'b0;
                        endcase
                        state_q <= S_DONE;
                    end
                end
                S_IPR: begin
                    if (!ipr_wr_valid_q) begin
                        ipr_wr_valid_q <= 1'b1;
                        case (ipr_step_q)
                            2'h0: begin
                                ipr_wr_addr_q <= {3'h0, sp_mode_q}; // [RULE10]
                                ipr_wr_data_q <= sp_q;
                            end
                            2'h1: begin
                                ipr_wr_addr_q <= `IPR_SAVED_PC; // [RULE10]
                                ipr_wr_data_q <= pc_q;
                            end
                            default: begin
                                ipr_wr_addr_q <= `IPR_SAVED_STATUS; // [RULE10]
                                ipr_wr_data_q <= {status_q[31:16], 1'b1, 1'b0,
                                    halt_q, status_q[7:0]};
                            end
                        endcase
                    end else if (ipr_wr_ready) begin
                        ipr_wr_valid_q <= 1'b0;
                        if (ipr_step_q == 2'h2) begin
                            new_pc_q <= `RESTART_PC; // [RULE9]
                            new_sp_q <= sp_q;
                            new_istack_q <= 1'b0;
                            new_ipl_load_q <= 1'b0;
                            restarted_q <= 1'b1;
                            state_q <= S_DONE;
                        end else begin
                            ipr_step_q <= ipr_step_q + 2'h1;
                        end
                    end
                end
                S_DONE: begin
                    done_q <= 1'b1;
                    boot_q <= 1'b0;
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule // cpu_exception_dispatch
`default_nettype wire

// *** hw/exc_defines.vh ***
// Constants for the exception and interrupt dispatch unit
`ifndef EXC_DEFINES_VH
`define EXC_DEFINES_VH
// ------
// Request kinds
// ------
`define K_PASSIVE 4'h0
`define K_MCHECK 4'h1
`define K_KSNV 4'h2
`define K_PWRFAIL 4'h3
`define K_ACV 4'h4
`define K_TNV 4'h5
`define K_ARITH 4'h6
`define K_CHM_KERNEL 4'h7
`define K_CHM_EXEC 4'h8
`define K_CHM_SUPER 4'h9
`define K_CHM_USER 4'ha
`define K_SOFTERR 4'hb
`define K_HARDERR 4'hc
`define K_VECDIS 4'hd
`define K_EMUL 4'he
`define K_RESTART 4'hf
// ------
// Vector table offsets
// ------
`define V_PASSIVE 10'h000
`define V_MCHECK 10'h004
`define V_KSNV 10'h008
`define V_PWRFAIL 10'h00c
`define V_ACV 10'h020
`define V_TNV 10'h024
`define V_ARITH 10'h034
`define V_CHM_KERNEL 10'h040
`define V_CHM_EXEC 10'h044
`define V_CHM_SUPER 10'h048
`define V_CHM_USER 10'h04c
`define V_SOFTERR 10'h054
`define V_HARDERR 10'h060
`define V_VECDIS 10'h068
`define V_EMUL_START 10'h0c8
`define V_EMUL_CONT 10'h0cc
// ------
// Priority levels, frame sizes, fields
// ------
`define IPL_PWRFAIL 5'h1e
`define IPL_SOFTERR 5'h1a
`define IPL_HARDERR 5'h1d
`define N_EMUL_SPEC 4'h8
`define N_MCHECK 4'h6
`define FRAME_EMUL 4'hc
`define FPD_BIT 27
`define ARITH_FIRST_FAULT 16'h0008
`define TABLE_BASE_LSB 9
// ------
// Restart sequence
// ------
`define RESTART_PC 32'he0040000
`define IPR_SAVED_PC 6'h2a
`define IPR_SAVED_STATUS 6'h2b
`define HALT_INTSTK_ERR 6'h04
`define HALT_POWERUP 6'h03
`endif

// *** verification/exc_dispatch_sva.sv ***
// Concurrent checks on the exception dispatch unit ports
`timescale 1ns/1ps
`default_nettype none
module exc_dispatch_sva (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Request and result
    input wire logic req_ready,
    input wire logic done_q,
    input wire logic restarted_q,
    input wire logic [31:0] new_pc_q,
    input wire logic new_istack_q,
    // Memory and register ports
    input wire logic push_valid_q,
    input wire logic push_ready,
    input wire logic push_err,
    input wire logic [31:0] push_addr_q,
    input wire logic fetch_valid_q,
    input wire logic fetch_ready,
    input wire logic [31:0] fetch_addr_q,
    input wire logic [31:0] fetch_data,
    input wire logic [31:0] vector_table_base,
    input wire logic ipr_wr_valid_q,
    input wire logic ipr_wr_ready,
    input wire logic [5:0] ipr_wr_addr_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ------
    // Helper state
    // ------
    logic [31:0] last_push_q, fetch_d_q;
    logic have_push_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            last_push_q <= 32'h0;
            fetch_d_q <= 32'h0;
            have_push_q <= 1'b0;
        end else begin
            if (push_valid_q && push_ready) begin
                last_push_q <= push_addr_q;
                have_push_q <= !push_err;
            end
            if (done_q) have_push_q <= 1'b0;
            if (fetch_valid_q && fetch_ready) fetch_d_q <= fetch_data;
        end
    end
    // ------
    // Assertions
    // ------
    a_push_hold: assert property (push_valid_q && !push_ready |=> push_valid_q && $stable(push_addr_q))
        else $error("push dropped before ready");
    a_push_step: assert property ($rose(push_valid_q) && have_push_q |-> push_addr_q == last_push_q - 32'h4)
        else $error("push address not one longword below");
    a_busy_refuse: assert property (push_valid_q |-> !req_ready)
        else $error("request accepted during push");
    a_fetch_table: assert property (fetch_valid_q |-> fetch_addr_q[31:9] == vector_table_base[31:9] && fetch_addr_q[1:0] == 2'b00)
        else $error("vector fetch outside table");
    a_fetch_done: assert property (fetch_valid_q && fetch_ready |-> ##[1:3] done_q)
        else $error("no completion after vector fetch");
    a_fetch_newpc: assert property (done_q && !restarted_q |-> new_pc_q == {fetch_d_q[31:2], 2'b00})
        else $error("new pc not from vector");
    a_restart_pc: assert property (done_q && restarted_q |-> new_pc_q == 32'he0040000)
        else $error("restart pc wrong");
    a_ipr_addr: assert property (ipr_wr_valid_q |-> ipr_wr_addr_q <= 6'h04 || ipr_wr_addr_q == 6'h2a || ipr_wr_addr_q == 6'h2b)
        else $error("restart write to wrong register");
    a_ipr_hold: assert property (ipr_wr_valid_q && !ipr_wr_ready |=> ipr_wr_valid_q && $stable(ipr_wr_addr_q))
        else $error("register write dropped before ready");
    a_ksnv_istack: assert property (fetch_valid_q && fetch_ready && fetch_addr_q[8:0] == 9'h008 |-> ##[1:3] (done_q && new_istack_q))
        else $error("stack abort not on interrupt stack");
    c_emul: cover property (fetch_valid_q && fetch_addr_q[8:0] == 9'h0c8);
    c_ksnv: cover property (fetch_valid_q && fetch_addr_q[8:0] == 9'h008);
    c_restart: cover property (done_q && restarted_q);
endmodule // exc_dispatch_sva
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking testbench for the exception dispatch unit
`timescale 1ns/1ps
`default_nettype none
`include "exc_defines.vh"
module testbench;
    // ------
    // Signals
    // ------
    logic clk_sys, rst, req_valid, push_ready, push_err, fetch_ready, ipr_wr_ready, req_on_istack;
    logic [3:0] req_kind;
    logic [31:0] req_pc, req_next_pc, req_status, req_sp, req_isp, fetch_data, vector_table_base;
    logic [31:0] param_data;
    logic [2:0] req_sp_mode;
    logic [4:0] req_level;
    logic [7:0] req_opcode;
    logic [15:0] req_word;
    logic [5:0] req_halt_code;
    wire req_ready, push_valid_q, fetch_valid_q, ipr_wr_valid_q, done_q, restarted_q;
    wire new_istack_q, new_ipl_load_q;
    wire [3:0] param_sel;
    wire [31:0] push_addr_q, push_data_q, fetch_addr_q, ipr_wr_data_q, new_pc_q, new_sp_q;
    wire [5:0] ipr_wr_addr_q;
    wire [4:0] new_ipl_q;
    logic [31:0] frame [0:15];
    logic [31:0] ipr_d [0:3];
    logic [5:0] ipr_a [0:3];
    logic [31:0] fetch_seen;
    logic err_arm;
    int npush, nipr, failures, n_tests;
    cpu_exception_dispatch cpu_exception_dispatch_i (
        .clk_sys, .rst, .req_valid, .req_ready, .req_kind, .req_pc, .req_next_pc, .req_status,
        .req_sp, .req_sp_mode, .req_on_istack, .req_isp, .req_level, .req_opcode, .req_word,
        .req_halt_code, .param_sel, .param_data, .vector_table_base, .push_valid_q, .push_addr_q,
        .push_data_q, .push_ready, .push_err, .fetch_valid_q, .fetch_addr_q, .fetch_ready,
        .fetch_data, .ipr_wr_valid_q, .ipr_wr_addr_q, .ipr_wr_data_q, .ipr_wr_ready, .done_q,
        .restarted_q, .new_pc_q, .new_sp_q, .new_istack_q, .new_ipl_load_q, .new_ipl_q
    );
    assign param_data = {28'hc0de000, param_sel};
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // ------
    // Memory and register responders
    // ------
    always @(posedge clk_sys) begin
        push_ready <= push_valid_q && !push_ready;
        push_err <= push_valid_q && !push_ready && err_arm;
        fetch_ready <= fetch_valid_q && !fetch_ready;
        ipr_wr_ready <= ipr_wr_valid_q && !ipr_wr_ready;
        if (push_valid_q && push_ready) begin
            frame[4'((req_sp - push_addr_q) >> 2)] <= push_data_q;
            npush <= npush + 1;
            if (push_err) err_arm <= 1'b0;
        end
        if (fetch_valid_q && fetch_ready) fetch_seen <= fetch_addr_q;
        if (ipr_wr_valid_q && ipr_wr_ready) begin
            ipr_a[nipr[1:0]] <= ipr_wr_addr_q;
            ipr_d[nipr[1:0]] <= ipr_wr_data_q;
            nipr <= nipr + 1;
        end
    end
    // ------
    // Shared tasks
    // ------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_done;
        for (int i = 0; i < 400 && done_q !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk("done", {31'h0, done_q}, 32'h1);
    endtask
    task automatic run(input logic [3:0] kind, input logic [31:0] st);
        @(posedge clk_sys);
        npush = 0;
        nipr = 0;
        req_kind <= kind;
        req_status <= st;
        req_valid <= 1'b1;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        wait_done;
    endtask
    task automatic frame_chk(input logic [9:0] off, input int nw, input logic [31:0] pc);
        chk("vector addr", fetch_seen, {vector_table_base[31:9], 9'h0} + 32'(off));
        chk("push count", npush, nw);
        chk("saved status", frame[1], req_status);
        chk("saved pc", frame[2], pc);
        chk("new pc", new_pc_q, 32'h0000_2000);
    endtask
    task automatic rst_chk(input logic [5:0] halt);
        chk("restarted", {31'h0, restarted_q}, 32'h1);
        chk("restart pc", new_pc_q, 32'he0040000);
        chk("ipr count", nipr, 3);
        chk("sp ipr", {26'h0, ipr_a[0]}, {29'h0, req_sp_mode});
        chk("sp value", ipr_d[0], req_sp);
        chk("pc ipr", {26'h0, ipr_a[1]}, 32'h2a);
        chk("pc value", ipr_d[1], req_pc);
        chk("status ipr", {26'h0, ipr_a[2]}, 32'h2b);
        chk("status value", ipr_d[2], {req_status[31:16], 2'b10, halt, req_status[7:0]});
    endtask
    // ------
    // Scenarios
    // ------
    task automatic t_emul;
        run(`K_EMUL, 32'h0412_001f);
        frame_chk(10'h0c8, 12, req_next_pc);
        chk("opcode", frame[12], 32'h0000_00fd);
        chk("old pc", frame[11], req_pc);
        for (int k = 0; k < 8; k++) chk("specifier", frame[10-k], {28'hc0de000, 4'(k)});
        run(`K_EMUL, 32'h0800_001f);
        frame_chk(10'h0cc, 2, req_pc);
    endtask
    task automatic t_faults;
        run(`K_MCHECK, 32'h0000_0004);
        frame_chk(10'h004, 8, req_pc);
        for (int k = 0; k < 6; k++) chk("mcheck param", frame[8-k], {28'hc0de000, 4'(k)});
        run(`K_VECDIS, 32'h0000_0008);
        frame_chk(10'h068, 2, req_pc);
        for (int k = 0; k < 2; k++) begin
            run(`K_ACV + 4'(k), 32'h0000_0001);
            frame_chk(10'h020 + 10'(4 * k), 4, req_pc);
            chk("va", frame[4], 32'hc0de0000);
            chk("code", frame[3], 32'hc0de0001);
        end
    endtask
    task automatic t_traps;
        req_word <= 16'h0007;
        run(`K_ARITH, 32'h0000_0002);
        frame_chk(10'h034, 3, req_next_pc);
        chk("type code", frame[3], 32'h7);
        req_word <= 16'h0008;
        run(`K_ARITH, 32'h0000_0002);
        frame_chk(10'h034, 3, req_pc);
        req_word <= 16'h8001;
        for (int k = 0; k < 4; k++) begin
            run(`K_CHM_KERNEL + 4'(k), 32'h0000_0003);
            frame_chk(10'h040 + 10'(4 * k), 3, req_next_pc);
            chk("chm word", frame[3], 32'hffff_8001);
        end
    endtask
    task automatic t_ipl;
        logic [3:0] kd [0:3] = '{`K_PASSIVE, `K_PWRFAIL, `K_SOFTERR, `K_HARDERR};
        logic [9:0] of [0:3] = '{10'h000, 10'h00c, 10'h054, 10'h060};
        logic [4:0] lv [0:3] = '{5'h17, 5'h1e, 5'h1a, 5'h1d};
        for (int k = 0; k < 4; k++) begin
            run(kd[k], 32'h0000_0005);
            frame_chk(of[k], 2, req_pc);
            chk("ipl load", {31'h0, new_ipl_load_q}, 32'h1);
            chk("ipl", {27'h0, new_ipl_q}, {27'h0, lv[k]});
        end
    endtask
    task automatic t_stack_err;
        err_arm = 1'b1;
        run(`K_ACV, 32'h0000_0006);
        chk("ksnv vector", fetch_seen, {vector_table_base[31:9], 9'h008});
        chk("ksnv istack", {31'h0, new_istack_q}, 32'h1);
        chk("ksnv sp", new_sp_q, req_isp - 32'h8);
        err_arm = 1'b1;
        req_on_istack <= 1'b1;
        run(`K_ACV, 32'h0000_0006);
        rst_chk(6'h04);
        req_on_istack <= 1'b0;
        req_halt_code <= 6'h06;
        run(`K_RESTART, 32'h0004_1111);
        rst_chk(6'h06);
    endtask
    task automatic end_sim;
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ------
    // Main sequence and watchdog
    // ------
    initial begin
        failures = 0;
        n_tests = 0;
        npush = 0;
        nipr = 0;
        err_arm = 1'b0;
        rst = 1'b1;
        {req_valid, req_on_istack} = 2'h0;
        req_kind = 4'h0;
        req_pc = 32'h0000_0400;
        req_next_pc = 32'h0000_0408;
        req_status = 32'h0412_34a5;
        req_sp = 32'h0000_1000;
        req_isp = 32'h0000_3000;
        req_sp_mode = 3'h2;
        req_level = 5'h17;
        req_opcode = 8'hfd;
        req_word = 16'h8001;
        req_halt_code = 6'h00;
        fetch_data = 32'h0000_2002;
        vector_table_base = 32'h0001_41ff;
        fetch_seen = 32'h0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        wait_done;
        rst_chk(6'h03);
        t_emul;
        t_faults;
        t_traps;
        t_ipl;
        t_stack_err;
        end_sim;
    end
    initial begin
        #(20 * 20000);
        failures++;
        end_sim;
    end
endmodule // testbench
bind cpu_exception_dispatch exc_dispatch_sva exc_dispatch_sva_i (
    .clk_sys, .rst, .req_ready, .done_q, .restarted_q, .new_pc_q, .new_istack_q,
    .push_valid_q, .push_ready, .push_err, .push_addr_q, .fetch_valid_q, .fetch_ready,
    .fetch_addr_q, .fetch_data, .vector_table_base, .ipr_wr_valid_q, .ipr_wr_ready,
    .ipr_wr_addr_q
);
`default_nettype wire
